// ### rtl/serial_port_consts.svh
// register offsets, reset values and counts for the serial port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define SP_ADDR_W 8
`define SP_OFF_CFG 8'h00
`define SP_OFF_CTL 8'h04
`define SP_OFF_NINTH 8'h08
`define SP_OFF_STATUS 8'h0c
`define SP_OFF_DATA 8'h10
`define SP_OFF_BAUD 8'h14
// ****************************************
// reset values and counts
// ****************************************
`define SP_CFG_RESET 8'h00
`define SP_CTL_RESET 8'h00
`define SP_BAUD_RESET 16'h0103
`define SP_LEN_SHORT 4'd10
`define SP_LEN_LONG 4'd11
`define SP_BITS_W 4
`endif

// ### rtl/serial_port_control.sv
// serial port control: apb registers, transmitter, receiver and pin takeover
//
// Summary of operation
// - module on drives tx pin always
// - module on reads rx pin unless loopback
// - loopback feeds transmitter output to receiver
// - module off sets empty/done, masks tx irq
// - polarity flip inverts every transmitted level
// - length select gives 10 or 11 bits
// - parity takes character msb position
// - parity select: one odd, zero even
// - wake by address mark or idle line
// - idle count after stop or start
// - tx irq from empty or done flags
// - rx irq from full or idle flags
// - tx on sends preamble of ones
// - tx off finishes current character first
// - tx off-on mid-character queues idle character
// - rx off keeps receiver flags
// - standby masks rx irq until wake
// - break toggle sends break then one
// - break before preamble replaces the preamble
// - reset clears both control registers
// - ninth bit travels with data byte
// - address wake sets full, idle wake not
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port_control #(
	parameter int DIV_W = 16
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`SP_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic rxd_pin_in,
	output logic txd_pin_out,
	output logic txd_pin_oe_out,
	input wire logic port_tx_data_in,
	input wire logic port_b_direction_in,
	output logic tx_irq_out,
	output logic rx_irq_out
);
	import serial_port_pkg::*;

	// ****************************************
	// elaboration check
	// ****************************************
	if (DIV_W < 4 || DIV_W > 16)
	begin : g_bad_div
		$error("DIV_W must lie in 4..16");
	end

	line_config_s cfg_reg;
	enable_irq_s ctl_reg;
	status_s stat;
	tx_state_e tx_state_reg;
	rx_state_e rx_state_reg;
	logic tx_ninth_bit_reg, rx_ninth_bit_reg;
	logic [7:0] tx_data_reg, rx_data_reg;
	logic [DIV_W-1:0] baud_div_reg, baud_cnt_reg;
	logic [31:0] prdata_reg, rd_mux;
	logic tx_buffer_empty_reg, rx_buffer_full_reg;
	logic idle_flag_reg, framing_err_reg, parity_err_reg;
	logic [10:0] tx_shift_reg;
	logic [`SP_BITS_W-1:0] tx_bits_reg, rx_bits_reg, idle_cnt_reg;
	logic tx_is_break_reg, preamble_pend_reg, tx_on_prev_reg;
	logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_filt_reg;
	logic [DIV_W:0] rx_cnt_reg;
	logic [9:0] rx_shift_reg;
	logic rx_done_reg, idle_armed_reg, txd_oe_reg;

	// ****************************************
	// apb decode
	// ****************************************
	wire access = psel_in & penable_in;
	wire hit_cfg = paddr_in == `SP_OFF_CFG;
	wire hit_ctl = paddr_in == `SP_OFF_CTL;
	wire hit_ninth = paddr_in == `SP_OFF_NINTH;
	wire hit_stat = paddr_in == `SP_OFF_STATUS;
	wire hit_data = paddr_in == `SP_OFF_DATA;
	wire hit_baud = paddr_in == `SP_OFF_BAUD;
	wire mapped = hit_cfg | hit_ctl | hit_ninth | hit_stat | hit_data | hit_baud;
	wire wr = access & pwrite_in;
	wire data_wr = wr & hit_data;
	wire data_rd = access & ~pwrite_in & hit_data;
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~mapped;
	assign prdata_out = prdata_reg;

	// read selection, unmapped reads zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (1'b1)
			hit_cfg: rd_mux[7:0] = cfg_reg;
			hit_ctl: rd_mux[7:0] = ctl_reg;
			hit_ninth: rd_mux[7:0] = {rx_ninth_bit_reg, tx_ninth_bit_reg, 6'h00};
			hit_stat: rd_mux[7:0] = stat;
			hit_data: rd_mux[7:0] = rx_data_reg;
			hit_baud: rd_mux[DIV_W-1:0] = baud_div_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			prdata_reg <= 32'h0000_0000;
		else if (psel_in & ~penable_in & ~pwrite_in)
			prdata_reg <= rd_mux;
	end

	// ****************************************
	// control registers
	// ****************************************
	wire module_on = cfg_reg.serial_module_on;
	wire m9 = cfg_reg.char_length_select;
	wire odd = cfg_reg.parity_odd_sel;
	wire par_on = cfg_reg.parity_on;
	wire rx_en = module_on & ctl_reg.rx_on;
	wire tx_go = module_on & ctl_reg.tx_on;
	wire [`SP_BITS_W-1:0] frame_len = m9 ? `SP_LEN_LONG : `SP_LEN_SHORT;
	logic wake_addr, idle_event;
	wire wake_idle = idle_event & ctl_reg.rx_standby & ~cfg_reg.wake_on_addr_mark;

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			cfg_reg <= `SP_CFG_RESET;
		else if (wr & hit_cfg)
			cfg_reg <= pwdata_in[7:0];
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ctl_reg <= `SP_CTL_RESET;
		else if (wr & hit_ctl)
			ctl_reg <= pwdata_in[7:0];
		else if (wake_addr | wake_idle)
			ctl_reg.rx_standby <= 1'b0;
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tx_ninth_bit_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			baud_div_reg <= DIV_W'(`SP_BAUD_RESET);
		end
		else
		begin
			if (wr & hit_ninth)
				tx_ninth_bit_reg <= pwdata_in[6];
			if (data_wr)
				tx_data_reg <= pwdata_in[7:0];
			if (wr & hit_baud)
				baud_div_reg <= pwdata_in[DIV_W-1:0];
		end
	end

	// ****************************************
	// baud divider, one-cycle bit tick
	// ****************************************
	wire tick = module_on & (baud_cnt_reg == '0);
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			baud_cnt_reg <= '0;
		else if (!module_on | tick)
			baud_cnt_reg <= baud_div_reg;
		else
			baud_cnt_reg <= baud_cnt_reg - 1'b1;
	end

	// ****************************************
	// transmitter
	// ****************************************
	// parity into msb
	wire par7 = ^tx_data_reg[6:0] ^ odd;
	wire par8 = ^tx_data_reg ^ odd;
	wire bit7 = (par_on & ~m9) ? par7 : tx_data_reg[7];
	wire bit8 = par_on ? par8 : tx_ninth_bit_reg;
	wire [10:0] data_frame = m9 ? {1'b1, bit8, bit7, tx_data_reg[6:0], 1'b0}
		: {2'b11, bit7, tx_data_reg[6:0], 1'b0};

	wire in_frame = tx_state_reg == TX_FRAME;
	wire tx_end = tick & ((in_frame & tx_bits_reg == 4'd1) | tx_state_reg == TX_ONE);
	wire goto_one = tx_end & in_frame & tx_is_break_reg & ~ctl_reg.break_send;
	wire tx_free = tick & ((tx_state_reg == TX_IDLE) | tx_end) & ~goto_one & tx_go;
	wire ld_brk = tx_free & ctl_reg.break_send;
	wire ld_pre = tx_free & ~ctl_reg.break_send & preamble_pend_reg;
	wire ld_dat = tx_free & ~ctl_reg.break_send & ~preamble_pend_reg & ~tx_buffer_empty_reg;
	wire tx_rise = ctl_reg.tx_on & ~tx_on_prev_reg;
	wire tx_level = in_frame ? tx_shift_reg[0] : 1'b1;
	wire tx_pin_level = tx_level ^ cfg_reg.tx_polarity_flip;

	// shifter state
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= '1;
			tx_bits_reg <= '0;
			tx_is_break_reg <= 1'b0;
		end
		else if (!module_on)
			tx_state_reg <= TX_IDLE;
		else if (goto_one)
			tx_state_reg <= TX_ONE;
		else if (ld_pre | ld_brk | ld_dat)
		begin
			tx_state_reg <= TX_FRAME;
			tx_shift_reg <= ld_dat ? data_frame : {11{ld_pre}};
			tx_bits_reg <= frame_len;
			tx_is_break_reg <= ld_brk;
		end
		else if (tx_end)
			tx_state_reg <= TX_IDLE;
		else if (tick & in_frame)
		begin
			tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
			tx_bits_reg <= tx_bits_reg - 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tx_buffer_empty_reg <= 1'b1;
			preamble_pend_reg <= 1'b0;
			tx_on_prev_reg <= 1'b0;
		end
		else
		begin
			tx_buffer_empty_reg <= ~module_on | ld_dat | (tx_buffer_empty_reg & ~data_wr);
			preamble_pend_reg <= module_on & (tx_rise | (preamble_pend_reg & ~ld_pre & ~ld_brk));
			tx_on_prev_reg <= ctl_reg.tx_on;
		end
	end

	wire tx_done = tx_buffer_empty_reg & (tx_state_reg == TX_IDLE)
		& ~preamble_pend_reg & ~(tx_go & ctl_reg.break_send);

	// pin takeover, open drain pulls low only
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			txd_oe_reg <= 1'b0;
		else if (module_on)
			txd_oe_reg <= ~tx_pin_level;
		else
			txd_oe_reg <= port_b_direction_in & ~port_tx_data_in;
	end
	assign txd_pin_out = 1'b0;
	assign txd_pin_oe_out = txd_oe_reg;

	// ****************************************
	// receiver
	// ****************************************
	// pin synchroniser, change taken when stages agree
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			rx_filt_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg <= rxd_pin_in;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_filt_reg <= rx_s3_reg;
		end
	end

	wire rx_line = cfg_reg.internal_loopback ? tx_pin_level : rx_filt_reg;
	wire [DIV_W:0] bit_full = {1'b0, baud_div_reg};
	wire [DIV_W:0] bit_half = {2'b00, baud_div_reg[DIV_W-1:1]};
	wire rx_zero = rx_cnt_reg == '0;

	// start detect and bit sampling
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= '0;
			rx_bits_reg <= '0;
			rx_shift_reg <= '0;
			rx_done_reg <= 1'b0;
		end
		else
		begin
			rx_done_reg <= 1'b0;
			rx_cnt_reg <= rx_zero ? bit_full : rx_cnt_reg - 1'b1;
			case (rx_state_reg)
				RX_IDLE:
				begin
					rx_cnt_reg <= bit_half;
					if (rx_en & ~rx_line)
						rx_state_reg <= RX_START;
				end
				RX_START:
					if (rx_zero)
					begin
						rx_state_reg <= rx_line ? RX_IDLE : RX_BITS;
						rx_bits_reg <= frame_len - 4'd1;
					end
				RX_BITS:
					if (rx_zero)
					begin
						rx_shift_reg <= {rx_line, rx_shift_reg[9:1]};
						rx_bits_reg <= rx_bits_reg - 1'b1;
						if (rx_bits_reg == 4'd1)
						begin
							rx_state_reg <= RX_IDLE;
							rx_done_reg <= 1'b1;
						end
					end
				default: rx_state_reg <= RX_IDLE;
			endcase
			if (!rx_en)
				rx_state_reg <= RX_IDLE;
		end
	end

	// align character, ninth copies bit seven in short mode
	wire [8:0] rx_char = m9 ? rx_shift_reg[8:0] : {rx_shift_reg[8], rx_shift_reg[8:1]};
	wire rx_msb = m9 ? rx_char[8] : rx_char[7];
	wire rx_par_bad = par_on & ((m9 ? ^rx_char : ^rx_char[7:0]) ^ odd);
	assign wake_addr = rx_done_reg & ctl_reg.rx_standby & cfg_reg.wake_on_addr_mark & rx_msb;
	wire rx_accept = rx_done_reg & (~ctl_reg.rx_standby | wake_addr);

	wire idle_hold = ~rx_line | (cfg_reg.idle_count_after_stop & rx_state_reg != RX_IDLE);
	assign idle_event = rx_en & tick & ~idle_hold & (idle_cnt_reg == frame_len - 4'd1);
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			idle_cnt_reg <= '0;
		else if (rx_en & tick)
			idle_cnt_reg <= idle_hold ? '0 : idle_cnt_reg + {3'b000, idle_cnt_reg != frame_len};
	end

	wire idle_set = idle_event & ~ctl_reg.rx_standby & idle_armed_reg;

	// receive data and flags, set wins over read clear
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rx_data_reg <= 8'h00;
			rx_ninth_bit_reg <= 1'b0;
			rx_buffer_full_reg <= 1'b0;
			idle_flag_reg <= 1'b0;
			framing_err_reg <= 1'b0;
			parity_err_reg <= 1'b0;
			idle_armed_reg <= 1'b0;
		end
		else
		begin
			if (rx_accept)
			begin
				rx_data_reg <= rx_char[7:0];
				rx_ninth_bit_reg <= rx_char[8];
			end
			rx_buffer_full_reg <= rx_accept | (rx_buffer_full_reg & ~data_rd);
			idle_flag_reg <= idle_set | (idle_flag_reg & ~data_rd);
			framing_err_reg <= (rx_accept & ~rx_shift_reg[9]) | (framing_err_reg & ~data_rd);
			parity_err_reg <= (rx_accept & rx_par_bad) | (parity_err_reg & ~data_rd);
			idle_armed_reg <= rx_accept | (idle_armed_reg & ~idle_set);
		end
	end

	// ****************************************
	// status and interrupt requests
	// ****************************************
	assign stat = '{tx_buffer_empty: tx_buffer_empty_reg, tx_done_flag: tx_done,
		rx_buffer_full: rx_buffer_full_reg, idle_flag: idle_flag_reg, zero: 2'b00,
		framing_err: framing_err_reg, parity_err: parity_err_reg};
	assign tx_irq_out = module_on & ((tx_buffer_empty_reg & ctl_reg.tx_empty_irq_en)
		| (tx_done & ctl_reg.tx_done_irq_en));
	assign rx_irq_out = ~ctl_reg.rx_standby & ((rx_buffer_full_reg & ctl_reg.rx_full_irq_en)
		| (idle_flag_reg & ctl_reg.idle_irq_en));
endmodule : serial_port_control
`default_nettype wire

// ### rtl/serial_port_pkg.sv
// types shared by the serial port control block
`default_nettype none
package serial_port_pkg;
	// line configuration register fields, msb first
	typedef struct packed {
		logic internal_loopback;
		logic serial_module_on;
		logic tx_polarity_flip;
		logic char_length_select;
		logic wake_on_addr_mark;
		logic idle_count_after_stop;
		logic parity_on;
		logic parity_odd_sel;
	} line_config_s;
	// enable and interrupt control register fields
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic idle_irq_en;
		logic tx_on;
		logic rx_on;
		logic rx_standby;
		logic break_send;
	} enable_irq_s;
	// status register fields
	typedef struct packed {
		logic tx_buffer_empty;
		logic tx_done_flag;
		logic rx_buffer_full;
		logic idle_flag;
		logic [1:0] zero;
		logic framing_err;
		logic parity_err;
	} status_s;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_FRAME = 2'b01,
		TX_ONE = 2'b10
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} rx_state_e;
endpackage : serial_port_pkg
`default_nettype wire

// ### tb/serial_port_control_checker.sv
// port assertions for the serial port control block
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port_control_checker #(
	parameter int DIV_W = 16
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`SP_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic rxd_pin_in,
	input wire logic txd_pin_out,
	input wire logic txd_pin_oe_out,
	input wire logic port_tx_data_in,
	input wire logic port_b_direction_in,
	input wire logic tx_irq_out,
	input wire logic rx_irq_out
);
	logic [7:0] cfg_reg;
	logic [7:0] ctl_reg;
	// access decode
	wire logic acc = psel_in && penable_in;
	wire logic wr_cfg = acc && pwrite_in && paddr_in == `SP_OFF_CFG;
	wire logic wr_ctl = acc && pwrite_in && paddr_in == `SP_OFF_CTL;
	wire logic mapped = paddr_in[1:0] == 2'b00 && paddr_in <= `SP_OFF_BAUD;
	// shadow of both control registers
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cfg_reg <= 8'h00;
			ctl_reg <= 8'h00;
		end
		else
		begin
			if (wr_cfg)
				cfg_reg <= pwdata_in[7:0];
			if (wr_ctl)
				ctl_reg <= pwdata_in[7:0];
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	// read setup then access
	sequence rd_at(logic [7:0] a);
		psel_in && !penable_in && !pwrite_in && paddr_in == a ##1 acc;
	endsequence
	chk_unmapped_err: assert property (pslverr_out == (acc && !mapped))
		else $error("slave error does not follow address decode");
	chk_cfg_read: assert property (rd_at(`SP_OFF_CFG) |-> prdata_out == {24'h0, cfg_reg})
		else $error("line config read back wrong");
	chk_ctl_read: assert property (rd_at(`SP_OFF_CTL) |-> prdata_out == {24'h0, ctl_reg})
		else $error("enable control read back wrong");
	chk_status_zero: assert property (rd_at(`SP_OFF_STATUS) |-> prdata_out[31:8] == 24'h0)
		else $error("status upper bits not zero");
	chk_port_pin: assert property ($past(rst_b_in) && !$past(cfg_reg[6]) |->
		txd_pin_oe_out == $past(port_b_direction_in && !port_tx_data_in))
		else $error("port does not own pin while module off");
	chk_off_txirq: assert property (!cfg_reg[6] |-> !tx_irq_out)
		else $error("tx interrupt while module off");
	chk_txirq_mask: assert property (ctl_reg[7:6] == 2'b00 |-> !tx_irq_out)
		else $error("tx interrupt while masked");
	chk_rxirq_mask: assert property (ctl_reg[5:4] == 2'b00 |-> !rx_irq_out)
		else $error("rx interrupt while masked");
	chk_reset_quiet: assert property ($rose(rst_b_in) |-> !txd_pin_oe_out && !tx_irq_out && !rx_irq_out)
		else $error("outputs active after reset");
endmodule : serial_port_control_checker
`default_nettype wire

// ### tb/serial_port_control_tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port_control_tb;
	localparam int BIT = 4;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic port_tx_data_in = 1'b1;
	logic port_b_direction_in = 1'b0;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, txd_pin_out, txd_pin_oe_out, tx_irq_out, rx_irq_out;
	logic rxd;
	logic [8:0] word;
	logic [31:0] rd;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	// open drain line with pull-up
	wire logic line = txd_pin_oe_out ? txd_pin_out : 1'b1;
	serial_port_control #(.DIV_W(16)) dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .rxd_pin_in(rxd), .txd_pin_out(txd_pin_out),
		.txd_pin_oe_out(txd_pin_oe_out), .port_tx_data_in(port_tx_data_in),
		.port_b_direction_in(port_b_direction_in), .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
	serial_remote #(.BIT(BIT)) remote (.clk_in(clock_in), .line_in(line), .rxd_out(rxd), .word_out(word));
	// 40 MHz clock
	initial
	begin
		forever
			#12.5 clock_in = ~clock_in;
	end
	// run limit
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			finish_test();
		end
	end
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
		tests_run++;
		if (seen !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, seen);
		end
	endtask : check
	// one apb transfer, read data kept in rd
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		do
			@(posedge clock_in);
		while (pready_out !== 1'b1);
		rd = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(s, rd, e);
	endtask : rdchk
	// counts cycles while the line holds v
	task automatic hold_count(input logic v, input int lim);
		while (line === v && n < lim)
		begin
			@(posedge clock_in);
			n++;
		end
	endtask : hold_count
	task automatic t_reset();
		rdchk("line_config", `SP_OFF_CFG, 32'h0);
		rdchk("enable_irq", `SP_OFF_CTL, 32'h0);
		rdchk("unmapped", 8'h18, 32'h0);
	endtask : t_reset
	task automatic t_irq();
		apb(1'b1, `SP_OFF_CTL, 32'hf0);
		@(negedge clock_in);
		check("tx_irq_off", tx_irq_out, 1'b0);
		apb(1'b1, `SP_OFF_CFG, 32'h40);
		@(negedge clock_in);
		check("tx_irq_on", tx_irq_out, 1'b1);
		check("rx_irq", rx_irq_out, 1'b0);
		rdchk("enable_irq", `SP_OFF_CTL, 32'hf0);
		apb(1'b1, `SP_OFF_CTL, 32'h00);
	endtask : t_irq
	task automatic t_pins();
		apb(1'b1, `SP_OFF_CFG, 32'h00);
		port_b_direction_in <= 1'b1;
		port_tx_data_in <= 1'b0;
		repeat (2) @(negedge clock_in);
		check("port_drive", line, 1'b0);
		apb(1'b1, `SP_OFF_CFG, 32'h40);
		repeat (2) @(negedge clock_in);
		check("takeover", line, 1'b1);
		apb(1'b1, `SP_OFF_CFG, 32'h60);
		repeat (2) @(negedge clock_in);
		check("idle_flip", line, 1'b0);
		apb(1'b1, `SP_OFF_CFG, 32'h40);
		port_b_direction_in <= 1'b0;
		port_tx_data_in <= 1'b1;
	endtask : t_pins
	task automatic t_tx();
		remote.nb = 9;
		apb(1'b1, `SP_OFF_CFG, 32'h50);
		apb(1'b1, `SP_OFF_NINTH, 32'h40);
		apb(1'b1, `SP_OFF_CTL, 32'h08);
		apb(1'b1, `SP_OFF_DATA, 32'h3c);
		n = 3;
		hold_count(1'b1, 500);
		check("preamble", n >= 11 * BIT, 1'b1);
		repeat (12 * BIT) @(posedge clock_in);
		check("frame", word, 9'h13c);
	endtask : t_tx
	task automatic t_loop();
		remote.level(1'b0);
		apb(1'b1, `SP_OFF_CFG, 32'hc0);
		apb(1'b1, `SP_OFF_CTL, 32'h0c);
		apb(1'b1, `SP_OFF_DATA, 32'ha5);
		repeat (25 * BIT) @(posedge clock_in);
		rdchk("loop_data", `SP_OFF_DATA, 32'ha5);
		remote.level(1'b1);
	endtask : t_loop
	task automatic t_parity();
		apb(1'b1, `SP_OFF_CFG, 32'h43);
		apb(1'b1, `SP_OFF_CTL, 32'h24);
		remote.send(9'h0c1, 8);
		repeat (8) @(posedge clock_in);
		check("rx_irq_full", rx_irq_out, 1'b1);
		apb(1'b0, `SP_OFF_STATUS, 32'h0);
		check("odd_ok", {rd[5], rd[0]}, 2'b10);
		apb(1'b0, `SP_OFF_DATA, 32'h0);
		remote.send(9'h041, 8);
		repeat (8) @(posedge clock_in);
		apb(1'b0, `SP_OFF_STATUS, 32'h0);
		check("odd_bad", {rd[5], rd[0]}, 2'b11);
		apb(1'b0, `SP_OFF_DATA, 32'h0);
	endtask : t_parity
	task automatic t_break();
		// tx on and break send written only with module on
		apb(1'b1, `SP_OFF_CTL, 32'h09);
		n = 0;
		hold_count(1'b1, 500);
		n = 0;
		hold_count(1'b0, 30 * BIT);
		check("break_run", n, 30 * BIT);
		apb(1'b1, `SP_OFF_CTL, 32'h08);
		repeat (12 * BIT) @(posedge clock_in);
		check("after_break", line, 1'b1);
	endtask : t_break
	task automatic finish_test();
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	// main sequence
	initial
	begin
		repeat (4) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_reset();
		apb(1'b1, `SP_OFF_BAUD, BIT - 1);
		t_irq();
		t_pins();
		t_tx();
		t_loop();
		t_parity();
		t_break();
		finish_test();
	end
endmodule : serial_port_control_tb
bind serial_port_control serial_port_control_checker #(.DIV_W(DIV_W)) chk (.clock_in(clock_in),
	.rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .rxd_pin_in(rxd_pin_in), .txd_pin_out(txd_pin_out),
	.txd_pin_oe_out(txd_pin_oe_out), .port_tx_data_in(port_tx_data_in),
	.port_b_direction_in(port_b_direction_in), .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
`default_nettype wire

// ### tb/serial_remote.sv
// remote serial device model on the tx and rx lines
`timescale 1ns/10ps
`default_nettype none
module serial_remote #(
	parameter int BIT = 4
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic rxd_out,
	output logic [8:0] word_out
);
	int nb = 8;
	// one start bit, then lsb first
	initial
	begin
		rxd_out = 1'b1;
		word_out = 9'h000;
		forever
		begin
			@(negedge line_in);
			word_out = 9'h000;
			repeat (BIT / 2) @(posedge clk_in);
			for (int i = 0; i < nb; i++)
			begin
				repeat (BIT) @(posedge clk_in);
				word_out[i] = line_in;
			end
			repeat (BIT) @(posedge clk_in);
		end
	end
	// puts a level on the receive line
	task automatic level(input logic v);
		@(posedge clk_in);
		rxd_out <= v;
	endtask : level
	task automatic send(input logic [8:0] w, input int n);
		level(1'b0);
		for (int i = 0; i < n; i++)
		begin
			repeat (BIT - 1) @(posedge clk_in);
			level(w[i]);
		end
		repeat (BIT - 1) @(posedge clk_in);
		level(1'b1);
		repeat (2 * BIT) @(posedge clk_in);
	endtask : send
endmodule : serial_remote
`default_nettype wire
